// ==== lpc_ctrl.sv ====
// Low-power mode controller: APB registers, mode sequencer and gating outputs
// What this block does
// - Low-power modes are entered only on the halt instruction; register writes alone never change mode.
// - Halt with standby select 0 and no clock-stop conditions enters sleep.
// - Clock-stop needs select 0, enable 1, B and D all ones, C upper all ones.
// - Clock-stop also needs module-stop A all ones except bits five and four.
// - Halt with standby select 1 and deep select 0 enters software standby.
// - Besides reset, only interrupt events leave any low-power mode.
// - Clock-stop wakes on pins, timer, calendar, watchdog, USB, monitors, oscillator-stop.
// - Software standby wakes as clock-stop, without eight-bit timer and oscillator-stop.
// - Main and sub crystal oscillators may run in every mode.
// - Internal oscillators and PLL stop in both standby modes.
// - Free watchdog runs except deep standby; main watchdog stops in all low-power modes.
// - Calendar clock, voltage monitor and power-on reset stay alive always.
// - Memories run in sleep, hold in stop modes; eight-bit timer stops in standby.
// - Deep standby powers off core, RAM, timers, peripherals; flash, ports keep settings.
// - A control bit picks retain or lose for standby RAM and USB in deep standby.
// - Halt with standby select 1 and deep select 1 enters deep standby.
// - Deep standby wake holds internal reset a fixed time, then restarts on low oscillator.
`timescale 1ns/10ps
`include "lpc_regs.svh"
module lpc_ctrl
    import lpc_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int DRST_CYCLES = `LPC_DRST_CYC
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic halt_exec,
    input wire lpc_wake_t wake_src,
    output lpc_gate_t gate,
    output logic clk_from_loco
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic [2:0] ctrl_q;
    logic [31:0] module_stop_reg_a_q;
    logic [31:0] module_stop_reg_b_q;
    logic [31:0] module_stop_reg_c_q;
    logic [31:0] module_stop_reg_d_q;
    logic [7:0] write_protect_reg_q;
    lpc_mode_t mode_q;
    lpc_mode_t mode_d;
    logic [11:0] drst_cnt_q;
    logic wake;
    logic acs_ok;
    logic access;
    logic done;
    logic wr_en;
    logic standby_select_bit;
    logic deep_standby_select_bit;
    logic deep_retain;
    logic drst_last;

    assign standby_select_bit = ctrl_q[`LPC_CTRL_STBY_SEL];
    assign deep_standby_select_bit = ctrl_q[`LPC_CTRL_DEEP_SEL];
    assign deep_retain = ctrl_q[`LPC_CTRL_RETAIN];
    assign drst_last = (drst_cnt_q == 12'(DRST_CYCLES - 1));

    // ------------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------------
    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        case (8'(a))
            `LPC_OFF_CTRL, `LPC_OFF_MSTP_A, `LPC_OFF_MSTP_B, `LPC_OFF_MSTP_C,
            `LPC_OFF_MSTP_D, `LPC_OFF_PROT, `LPC_OFF_STAT: addr_mapped = 1'b1;
            default: addr_mapped = 1'b0;
        endcase
    endfunction

    // Registers behind the write protect unlock
    function automatic logic addr_guarded(input logic [ADDR_W-1:0] a);
        case (8'(a))
            `LPC_OFF_CTRL, `LPC_OFF_MSTP_A, `LPC_OFF_MSTP_B, `LPC_OFF_MSTP_C,
            `LPC_OFF_MSTP_D: addr_guarded = 1'b1;
            default: addr_guarded = 1'b0;
        endcase
    endfunction

    function automatic logic clock_stop_ready(input logic [31:0] a, input logic [31:0] b,
                                              input logic [31:0] c, input logic [31:0] d);
        clock_stop_ready = a[`LPC_MSTP_A_CLK_STOP_EN] &
                           ((a | `LPC_MSTP_A_FREE) == `LPC_ALL_ONES) &
                           (b == `LPC_ALL_ONES) & (d == `LPC_ALL_ONES) &
                           (c[31:16] == `LPC_MSTP_C_HI_ONES);
    endfunction

    function automatic lpc_gate_t gate_for(input lpc_mode_t m, input logic retain);
        lpc_gate_t g;
        g = '0;
        g.main_osc_en = 1'b1;
        g.sub_osc_en = 1'b1;
        g.rtc_run = 1'b1;
        g.voltage_monitor_unit_run = 1'b1;
        g.por_run = 1'b1;
        g.int_rst_n = 1'b1;
        case (m)
            LPC_SLEEP: begin
                g.hoco_en = 1'b1;
                g.loco_en = 1'b1;
                g.pll_en = 1'b1;
                g.free_running_watchdog_run = 1'b1;
                g.ram_run = 1'b1;
                g.sram_run = 1'b1;
                g.flash_run = 1'b1;
                g.usb_run = 1'b1;
                g.eight_bit_timer_run = 1'b1;
                g.periph_run = 1'b1;
            end
            LPC_ACSTOP: begin
                g.hoco_en = 1'b1;
                g.loco_en = 1'b1;
                g.pll_en = 1'b1;
                g.free_running_watchdog_run = 1'b1;
                g.eight_bit_timer_run = 1'b1;
                g.io_hold = 1'b1;
            end
            LPC_SSTBY: begin
                g.free_running_watchdog_run = 1'b1;
                g.io_hold = 1'b1;
            end
            LPC_DSTBY: begin
                g.core_pwr_off = 1'b1;
                g.sram_pwr_off = ~retain;
                g.usb_pwr_off = ~retain;
                g.io_hold = 1'b1;
            end
            LPC_DRST: begin
                g.loco_en = 1'b1;
                g.int_rst_n = 1'b0;
                g.sram_pwr_off = ~retain;
                g.usb_pwr_off = ~retain;
                g.io_hold = 1'b1;
            end
            default: begin
                g.cpu_run = 1'b1;
                g.hoco_en = 1'b1;
                g.loco_en = 1'b1;
                g.pll_en = 1'b1;
                g.free_running_watchdog_run = 1'b1;
                g.main_watchdog_run = 1'b1;
                g.ram_run = 1'b1;
                g.sram_run = 1'b1;
                g.flash_run = 1'b1;
                g.usb_run = 1'b1;
                g.eight_bit_timer_run = 1'b1;
                g.periph_run = 1'b1;
            end
        endcase
        gate_for = g;
    endfunction

    // ------------------------------------------------------------------------
    // APB handshake
    // ------------------------------------------------------------------------
    assign access = psel & penable;
    assign done = access & pready;
    // Writes to guarded registers need the unlock bit set beforehand
    assign wr_en = done & pwrite & addr_mapped(paddr) &
                   (~addr_guarded(paddr) | write_protect_reg_q[`LPC_PROT_LP_EN]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= access & ~pready;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= access & ~pready & (~addr_mapped(paddr) | (pwrite & addr_guarded(paddr) &
                       ~write_protect_reg_q[`LPC_PROT_LP_EN]));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (access & ~pready & ~pwrite) begin
            case (8'(paddr))
                `LPC_OFF_CTRL: prdata <= {29'h0000_0000, ctrl_q};
                `LPC_OFF_MSTP_A: prdata <= module_stop_reg_a_q;
                `LPC_OFF_MSTP_B: prdata <= module_stop_reg_b_q;
                `LPC_OFF_MSTP_C: prdata <= module_stop_reg_c_q;
                `LPC_OFF_MSTP_D: prdata <= module_stop_reg_d_q;
                `LPC_OFF_PROT: prdata <= {24'h00_0000, write_protect_reg_q};
                `LPC_OFF_STAT: prdata <= {27'h000_0000, acs_ok, clk_from_loco, mode_q};
                default: prdata <= 32'h0000_0000;
            endcase
        end else if (done) begin
            prdata <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `LPC_CTRL_RST;
            module_stop_reg_a_q <= `LPC_MSTP_A_RST;
            module_stop_reg_b_q <= `LPC_MSTP_BCD_RST;
            module_stop_reg_c_q <= `LPC_MSTP_BCD_RST;
            module_stop_reg_d_q <= `LPC_MSTP_BCD_RST;
        end else if (wr_en) begin
            case (8'(paddr))
                `LPC_OFF_CTRL: ctrl_q <= pwdata[2:0];
                `LPC_OFF_MSTP_A: module_stop_reg_a_q <= pwdata;
                `LPC_OFF_MSTP_B: module_stop_reg_b_q <= pwdata;
                `LPC_OFF_MSTP_C: module_stop_reg_c_q <= pwdata;
                `LPC_OFF_MSTP_D: module_stop_reg_d_q <= pwdata;
                default: ctrl_q <= ctrl_q;
            endcase
        end
    end

    // Protect register changes only when the key byte matches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_protect_reg_q <= `LPC_PROT_RST;
        end else if (wr_en && 8'(paddr) == `LPC_OFF_PROT &&
                     pwdata[`LPC_PROT_KEY_LSB +: 8] == `LPC_PROT_KEY) begin
            write_protect_reg_q <= pwdata[7:0];
        end
    end

    assign acs_ok = clock_stop_ready(module_stop_reg_a_q, module_stop_reg_b_q,
                                     module_stop_reg_c_q, module_stop_reg_d_q);

    // ------------------------------------------------------------------------
    // Wake event selection
    // ------------------------------------------------------------------------
    lpc_wake_sel u_wake_sel (
        .pclk(pclk),
        .presetn(presetn),
        .mode(mode_q),
        .src(wake_src),
        .wake(wake)
    );

    // ------------------------------------------------------------------------
    // Mode sequencer
    // ------------------------------------------------------------------------
    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            LPC_NORMAL: begin
                if (halt_exec) begin
                    if (!standby_select_bit) begin
                        mode_d = acs_ok ? LPC_ACSTOP : LPC_SLEEP;
                    end else if (!deep_standby_select_bit) begin
                        mode_d = LPC_SSTBY;
                    end else begin
                        mode_d = LPC_DSTBY;
                    end
                end
            end
            LPC_SLEEP, LPC_ACSTOP, LPC_SSTBY: begin
                if (wake) begin
                    mode_d = LPC_NORMAL;
                end
            end
            LPC_DSTBY: begin
                if (wake) begin
                    mode_d = LPC_DRST;
                end
            end
            LPC_DRST: begin
                if (drst_last) begin
                    mode_d = LPC_NORMAL;
                end
            end
            default: mode_d = LPC_NORMAL;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= LPC_NORMAL;
        end else begin
            mode_q <= mode_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drst_cnt_q <= 12'h000;
        end else if (mode_q == LPC_DRST) begin
            drst_cnt_q <= drst_cnt_q + 12'h001;
        end else begin
            drst_cnt_q <= 12'h000;
        end
    end

    // Restart after deep standby runs from the low-speed oscillator until reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_from_loco <= 1'b0;
        end else if (mode_q == LPC_DRST && drst_last) begin
            clk_from_loco <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Gating outputs
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate <= gate_for(LPC_NORMAL, 1'b0);
        end else begin
            gate <= gate_for(mode_q, deep_retain);
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    property p_no_entry_without_halt;
        @(posedge pclk) disable iff (!presetn)
        (mode_q == LPC_NORMAL && !halt_exec) |=> (mode_q == LPC_NORMAL);
    endproperty
    a_no_entry_without_halt: assert property (p_no_entry_without_halt)
        else $error("mode left normal without halt");

    property p_sleep_entry;
        @(posedge pclk) disable iff (!presetn)
        (mode_q == LPC_NORMAL && halt_exec && !standby_select_bit && !acs_ok)
            |=> (mode_q == LPC_SLEEP);
    endproperty
    a_sleep_entry: assert property (p_sleep_entry)
        else $error("sleep not entered");

    property p_acstop_entry;
        @(posedge pclk) disable iff (!presetn)
        (mode_q == LPC_NORMAL && halt_exec && !standby_select_bit &&
         module_stop_reg_a_q[31] && (module_stop_reg_a_q | 32'h0000_0030) == 32'hFFFF_FFFF &&
         module_stop_reg_b_q == 32'hFFFF_FFFF && module_stop_reg_d_q == 32'hFFFF_FFFF &&
         module_stop_reg_c_q[31:16] == 16'hFFFF) |=> (mode_q == LPC_ACSTOP);
    endproperty
    a_acstop_entry: assert property (p_acstop_entry)
        else $error("clock stop not entered");

    property p_sstby_entry;
        @(posedge pclk) disable iff (!presetn)
        (mode_q == LPC_NORMAL && halt_exec && standby_select_bit && !deep_standby_select_bit)
            |=> (mode_q == LPC_SSTBY) ##1 (!gate.hoco_en && !gate.pll_en && !gate.loco_en);
    endproperty
    a_sstby_entry: assert property (p_sstby_entry)
        else $error("software standby entry or oscillator stop wrong");

    property p_dstby_entry;
        @(posedge pclk) disable iff (!presetn)
        (mode_q == LPC_NORMAL && halt_exec && standby_select_bit && deep_standby_select_bit)
            |=> (mode_q == LPC_DSTBY) ##1 gate.core_pwr_off;
    endproperty
    a_dstby_entry: assert property (p_dstby_entry)
        else $error("deep standby not entered");

    property p_sleep_any_irq;
        @(posedge pclk) disable iff (!presetn)
        (mode_q == LPC_SLEEP && wake_src.other) |=> ##1 (mode_q == LPC_NORMAL);
    endproperty
    a_sleep_any_irq: assert property (p_sleep_any_irq)
        else $error("sleep did not end on interrupt");

    property p_sstby_ignores_timer;
        @(posedge pclk) disable iff (!presetn)
        (mode_q == LPC_SSTBY && (wake_src.osc_stop || wake_src.eight_bit_timer) &&
         {wake_src.nmi, wake_src.ext_irq, wake_src.rtc_alarm, wake_src.rtc_period,
          wake_src.free_running_watchdog, wake_src.usb_susp_res, wake_src.volt_mon1,
          wake_src.volt_mon2} == '0) ##1 (mode_q == LPC_SSTBY) |=> (mode_q == LPC_SSTBY);
    endproperty
    a_sstby_ignores_timer: assert property (p_sstby_ignores_timer)
        else $error("software standby woke on excluded source");

    property p_drst_hold;
        @(posedge pclk) disable iff (!presetn)
        $rose(mode_q == LPC_DRST) |-> (mode_q == LPC_DRST)[*8] ##1 !gate.int_rst_n;
    endproperty
    a_drst_hold: assert property (p_drst_hold)
        else $error("internal reset hold too short");

    property p_always_on;
        @(posedge pclk) disable iff (!presetn)
        $changed(mode_q) |=> (gate.main_osc_en && gate.sub_osc_en && gate.rtc_run &&
                              gate.voltage_monitor_unit_run && gate.por_run);
    endproperty
    a_always_on: assert property (p_always_on)
        else $error("always-on block was gated");

    property p_protect;
        @(posedge pclk) disable iff (!presetn)
        (done && pwrite && 8'(paddr) == `LPC_OFF_CTRL && !write_protect_reg_q[1])
            |=> $stable(ctrl_q);
    endproperty
    a_protect: assert property (p_protect)
        else $error("protected write took effect");

endmodule

// ==== lpc_regs.svh ====
// Offsets, field positions, reset values and timing counts of the low-power controller
`ifndef LPC_REGS_SVH
`define LPC_REGS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define LPC_OFF_CTRL 8'h00
`define LPC_OFF_MSTP_A 8'h04
`define LPC_OFF_MSTP_B 8'h08
`define LPC_OFF_MSTP_C 8'h0C
`define LPC_OFF_MSTP_D 8'h10
`define LPC_OFF_PROT 8'h14
`define LPC_OFF_STAT 8'h18

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define LPC_CTRL_STBY_SEL 0
`define LPC_CTRL_DEEP_SEL 1
`define LPC_CTRL_RETAIN 2
`define LPC_MSTP_A_CLK_STOP_EN 31
`define LPC_PROT_LP_EN 1
`define LPC_PROT_KEY_LSB 8

// ----------------------------------------------------------------------------
// Reset values, keys and masks
// ----------------------------------------------------------------------------
`define LPC_CTRL_RST 3'h0
`define LPC_MSTP_A_RST 32'h0000_0000
`define LPC_MSTP_BCD_RST 32'hFFFF_FFFF
`define LPC_PROT_RST 8'h00
`define LPC_PROT_KEY 8'hA5
`define LPC_ALL_ONES 32'hFFFF_FFFF
`define LPC_MSTP_A_FREE 32'h0000_0030
`define LPC_MSTP_C_HI_ONES 16'hFFFF

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define LPC_CLK_NS 50
`define LPC_DRST_NS 1000
`define LPC_DRST_CYC ((`LPC_DRST_NS + `LPC_CLK_NS - 1) / `LPC_CLK_NS)

`endif

// ==== lpc_pkg.sv ====
// Types shared by the low-power controller modules
package lpc_pkg;

    // ------------------------------------------------------------------------
    // Operating modes
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        LPC_NORMAL = 3'b000,
        LPC_SLEEP = 3'b001,
        LPC_ACSTOP = 3'b010,
        LPC_SSTBY = 3'b011,
        LPC_DSTBY = 3'b100,
        LPC_DRST = 3'b101
    } lpc_mode_t;

    // ------------------------------------------------------------------------
    // Interrupt event inputs
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic nmi;
        logic [15:0] ext_irq;
        logic eight_bit_timer;
        logic rtc_alarm;
        logic rtc_period;
        logic free_running_watchdog;
        logic usb_susp_res;
        logic volt_mon1;
        logic volt_mon2;
        logic osc_stop;
        logic other;
    } lpc_wake_t;

    // ------------------------------------------------------------------------
    // Clock, power and hold controls toward the gated blocks
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic cpu_run;
        logic main_osc_en;
        logic sub_osc_en;
        logic hoco_en;
        logic loco_en;
        logic pll_en;
        logic free_running_watchdog_run;
        logic main_watchdog_run;
        logic ram_run;
        logic sram_run;
        logic flash_run;
        logic usb_run;
        logic eight_bit_timer_run;
        logic periph_run;
        logic rtc_run;
        logic voltage_monitor_unit_run;
        logic por_run;
        logic core_pwr_off;
        logic sram_pwr_off;
        logic usb_pwr_off;
        logic io_hold;
        logic int_rst_n;
    } lpc_gate_t;

endpackage

// ==== lpc_wake_sel.sv ====
// Selects which interrupt events end the current low-power mode
`timescale 1ns/10ps
module lpc_wake_sel
    import lpc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire lpc_mode_t mode,
    input wire lpc_wake_t src,
    output logic wake
);

    // ------------------------------------------------------------------------
    // Event sets per mode
    // ------------------------------------------------------------------------
    logic pin_ev;
    logic dsb_ev;
    logic ssb_ev;
    logic acs_ev;
    logic slp_ev;
    logic wake_d;

    assign pin_ev = src.nmi | (|src.ext_irq);
    assign dsb_ev = pin_ev | src.rtc_alarm | src.rtc_period | src.usb_susp_res |
                    src.volt_mon1 | src.volt_mon2;
    assign ssb_ev = dsb_ev | src.free_running_watchdog;
    assign acs_ev = ssb_ev | src.eight_bit_timer | src.osc_stop;
    assign slp_ev = acs_ev | src.other;

    always_comb begin
        case (mode)
            LPC_SLEEP: wake_d = slp_ev;
            LPC_ACSTOP: wake_d = acs_ev;
            LPC_SSTBY: wake_d = ssb_ev;
            LPC_DSTBY: wake_d = dsb_ev;
            default: wake_d = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake <= 1'b0;
        end else begin
            wake <= wake_d;
        end
    end

endmodule

// ==== lpc_cpu_model.sv ====
// Processor-side model: issues the halt pulse and interrupt levels
`timescale 1ns/10ps
module lpc_cpu_model
    import lpc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic do_halt,
    input wire lpc_wake_t wake_in,
    input wire lpc_gate_t gate,
    output logic halt_exec,
    output lpc_wake_t wake_src
);
    // A stopped core cannot execute another halt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halt_exec <= 1'b0;
            wake_src <= '0;
        end else begin
            halt_exec <= do_halt & gate.cpu_run;
            wake_src <= wake_in;
        end
    end
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the low-power mode controller
`timescale 1ns/10ps
module tb_top
    import lpc_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, do_halt = 0, er;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, halt_exec, clk_from_loco;
    lpc_wake_t wake_in = '0, wake_src, v;
    lpc_gate_t gate;
    int num_errors = 0, n_tests = 0;
    always #25 pclk = ~pclk;
    lpc_ctrl #(.DRST_CYCLES(10)) lpc_ctrl_inst(.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .halt_exec(halt_exec), .wake_src(wake_src),
        .gate(gate), .clk_from_loco(clk_from_loco));
    lpc_cpu_model lpc_cpu_model_inst(.pclk(pclk), .presetn(presetn), .do_halt(do_halt),
        .wake_in(wake_in), .gate(gate), .halt_exec(halt_exec), .wake_src(wake_src));
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_tests++;
        if (got !== ex) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic hold(input int c);
        repeat (c) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic stat(input logic [3:0] ex, input string nm);
        apb(1'b0, 8'h18, 32'h0000_0000);
        chk(nm, {28'h000_0000, ex}, {28'h000_0000, rd[3:0]});
    endtask
    task automatic halt();
        @(posedge pclk);
        do_halt <= 1'b1;
        @(posedge pclk);
        do_halt <= 1'b0;
        hold(3);
    endtask
    task automatic wake(input lpc_wake_t w);
        @(posedge pclk);
        wake_in <= w;
        hold(4);
        wake_in <= '0;
        hold(3);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic t_regs();
        apb(1'b1, 8'h00, 32'h0000_0001);
        chk("locked write err", 32'h0000_0001, {31'h0, er});
        apb(1'b1, 8'h14, 32'h0000_A502);
        apb(1'b0, 8'h1C, 32'h0000_0000);
        chk("unmapped err", 32'h0000_0001, {31'h0, er});
        apb(1'b1, 8'h00, 32'h0000_0001);
        hold(4);
        stat(4'h0, "write only mode");
        $display("registers test done");
    endtask
    task automatic t_sleep();
        apb(1'b1, 8'h00, 32'h0000_0000);
        halt();
        stat(4'h1, "sleep mode");
        chk("cpu run", 32'h0, {31'h0, gate.cpu_run});
        v = '0;
        v.other = 1'b1;
        wake(v);
        stat(4'h0, "sleep wake");
        $display("sleep test done");
    endtask
    task automatic t_clock_stop();
        apb(1'b1, 8'h04, 32'hFFFF_FFCF);
        halt();
        stat(4'h2, "clock stop mode");
        chk("timer clock stop", 32'h1, {31'h0, gate.eight_bit_timer_run});
        wake(v);
        stat(4'h2, "other ignored");
        v = '0;
        v.osc_stop = 1'b1;
        wake(v);
        stat(4'h0, "osc stop wake");
        $display("clock stop test done");
    endtask
    task automatic t_standby();
        apb(1'b1, 8'h00, 32'h0000_0001);
        halt();
        stat(4'h3, "standby mode");
        chk("hoco", 32'h0, {31'h0, gate.hoco_en});
        chk("timer standby", 32'h0, {31'h0, gate.eight_bit_timer_run});
        chk("free wdt standby", 32'h1, {31'h0, gate.free_running_watchdog_run});
        v.eight_bit_timer = 1'b1;
        wake(v);
        stat(4'h3, "osc stop and timer ignored");
        v = '0;
        v.ext_irq[9] = 1'b1;
        wake(v);
        stat(4'h0, "pin wake");
        $display("standby test done");
    endtask
    task automatic t_deep();
        apb(1'b1, 8'h00, 32'h0000_0007);
        halt();
        stat(4'h4, "deep mode");
        chk("core off", 32'h1, {31'h0, gate.core_pwr_off});
        chk("sram retain", 32'h0, {31'h0, gate.sram_pwr_off});
        @(posedge pclk);
        wake_in <= v;
        hold(2);
        stat(4'h5, "reset hold");
        chk("int reset", 32'h0, {31'h0, gate.int_rst_n});
        wake_in <= '0;
        hold(20);
        stat(4'h8, "loco restart");
        $display("deep standby test done");
    endtask
    task automatic t_reset();
        apb(1'b1, 8'h00, 32'h0000_0001);
        halt();
        stat(4'hB, "standby on loco");
        presetn <= 1'b0;
        hold(2);
        presetn <= 1'b1;
        stat(4'h0, "reset pin release");
        chk("cpu run after reset", 32'h1, {31'h0, gate.cpu_run});
        $display("reset test done");
    endtask
    initial begin
        hold(2);
        presetn <= 1'b1;
        t_regs();
        t_sleep();
        t_clock_stop();
        t_standby();
        t_deep();
        t_reset();
        close_out();
    end
    initial begin
        #200000;
        num_errors++;
        close_out();
    end
endmodule
